/* File: inc/ter_pkg.sv */
// Package for trigger and event routing: register map, fields, resets, encodings.
// Assumes a plain register port with read data one cycle after the read strobe.
package ter_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [3:0] REG_TRIG_SLOPE = 4'h0;
    localparam logic [3:0] REG_EVNT_SLOPE = 4'h4;
    localparam logic [3:0] REG_ENAB_CFG   = 4'h8;
    localparam logic [3:0] REG_BEG_CFG    = 4'hc;

    // Software command bits on the command port
    localparam int unsigned CMD_ENAB_BIT  = 0;
    localparam int unsigned CMD_BEG_BIT   = 1;

    // Field positions
    localparam int unsigned SLOPE_LSB     = 0;
    localparam int unsigned SRC_BIT       = 0;
    localparam int unsigned BLOCK_BIT     = 1;
    localparam int unsigned BEG_BLOCK_BIT = 0;

    // Slope encodings
    typedef enum logic [1:0]
    {
        TER_EDGE_RISING  = 2'h0,
        TER_EDGE_FALLING = 2'h1,
        TER_EDGE_BOTH    = 2'h2
    } ter_slope_t;

    // Enable source encodings
    typedef enum logic
    {
        TER_SRC_TRIG = 1'h0,
        TER_SRC_EVNT = 1'h1
    } ter_src_t;

    // Reset values
    localparam ter_slope_t RST_SLOPE = TER_EDGE_RISING;
    localparam ter_src_t   RST_SRC   = TER_SRC_TRIG;
    localparam logic       RST_BLOCK = 1'h0;

endpackage

/* File: inc/ter_edge_if.sv */
// Interface carrying one synchronised input, its slope and the detected edge.
// Assumes the driving side has already passed the pin through two flip-flops.
interface ter_edge_if;
    logic                 level;
    ter_pkg::ter_slope_t  slope;
    logic                 hit;

    modport det
    (
        input  level,
        input  slope,
        output hit
    );

    modport use_side
    (
        output level,
        output slope,
        input  hit
    );
endinterface

/* File: src/ter_edge_det.sv */
// Edge detector for one synchronised input with programmable slope.
// Assumes the level is already synchronous to i_mclk.
module ter_edge_det
(
    input  wire logic i_mclk,
    input  wire logic i_srst,
    ter_edge_if.det   e
);

    logic prev_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            prev_q <= 1'b0;
        else
            prev_q <= e.level;
    end

    ////////////////////////////////////////////////////////////////////////
    // Slope qualified edge
    always_comb
    begin
        unique case (e.slope)
            ter_pkg::TER_EDGE_RISING:  e.hit = e.level & ~prev_q;
            ter_pkg::TER_EDGE_FALLING: e.hit = ~e.level & prev_q;
            ter_pkg::TER_EDGE_BOTH:    e.hit = e.level ^ prev_q;
            default:                   e.hit = 1'b0;
        endcase
    end

endmodule

/* File: src/ter_route.sv */
// Trigger and event routing top: slopes, enable source, hardware input blocks,
// software enable and begin commands, one enable and one begin event pulse.
// Assumes asynchronous trigger, event and internal generator pins.
//
// Decided for this implementation: strobed register access and the register offsets.
module ter_route
(
    input  wire logic                       i_mclk,
    input  wire logic                       i_srst,
    input  wire logic                       i_trig_pin,
    input  wire logic                       i_evnt_pin,
    input  wire logic                       i_intgen_pin,
    input  wire logic [ter_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [ter_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic [ter_pkg::ADDR_W-1:0] i_cmd_addr,
    input  wire logic [1:0]                 i_cmd,
    output logic      [ter_pkg::DATA_W-1:0] o_rdata,
    output logic                            o_enable_evt,
    output logic                            o_begin_evt
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, two flops per pin
    localparam int unsigned N_PIN = 3;

    logic [N_PIN-1:0] pin_raw;
    logic [N_PIN-1:0] pin_sync;

    assign pin_raw = {i_intgen_pin, i_evnt_pin, i_trig_pin};

    for (genvar g = 0; g < N_PIN; g++)
    begin : g_sync
        logic stage1_q;
        logic stage2_q;

        always_ff @(posedge i_mclk)
        begin
            if (i_srst)
                stage1_q <= 1'h0;
            else
                stage1_q <= pin_raw[g];
        end

        // Only the second stage feeds logic
        always_ff @(posedge i_mclk)
        begin
            if (i_srst)
                stage2_q <= 1'h0;
            else
                stage2_q <= stage1_q;
        end

        assign pin_sync[g] = stage2_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data fields
    logic [1:0] wr_slope_code;
    logic       wr_src_bit;
    logic       wr_enab_block;
    logic       wr_beg_block;

    always_comb
    begin
        wr_slope_code = i_wdata[ter_pkg::SLOPE_LSB +: 2];
        wr_src_bit    = i_wdata[ter_pkg::SRC_BIT];
        wr_enab_block = i_wdata[ter_pkg::BLOCK_BIT];
        wr_beg_block  = i_wdata[ter_pkg::BEG_BLOCK_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    logic wr_trig_slope;
    logic wr_evnt_slope;
    logic wr_enab_cfg;
    logic wr_beg_cfg;
    logic slope_legal;

    always_comb
    begin
        // One strobe per register
        wr_trig_slope = i_wr && (i_addr == ter_pkg::REG_TRIG_SLOPE);
        wr_evnt_slope = i_wr && (i_addr == ter_pkg::REG_EVNT_SLOPE);
        wr_enab_cfg   = i_wr && (i_addr == ter_pkg::REG_ENAB_CFG);
        wr_beg_cfg    = i_wr && (i_addr == ter_pkg::REG_BEG_CFG);
        // Slope code 3 is refused
        slope_legal   = (wr_slope_code != 2'h3);
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    ter_pkg::ter_slope_t trig_slope_q;
    ter_pkg::ter_slope_t evnt_slope_q;
    ter_pkg::ter_src_t   enab_src_q;
    logic                enab_block_q;
    logic                beg_block_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            trig_slope_q <= ter_pkg::RST_SLOPE;
        else if (wr_trig_slope && slope_legal)
            trig_slope_q <= ter_pkg::ter_slope_t'(wr_slope_code);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            evnt_slope_q <= ter_pkg::RST_SLOPE;
        else if (wr_evnt_slope && slope_legal)
            evnt_slope_q <= ter_pkg::ter_slope_t'(wr_slope_code);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            enab_src_q <= ter_pkg::RST_SRC;
        else if (wr_enab_cfg)
            enab_src_q <= ter_pkg::ter_src_t'(wr_src_bit);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            enab_block_q <= ter_pkg::RST_BLOCK;
        else if (wr_enab_cfg)
            enab_block_q <= wr_enab_block;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            beg_block_q <= ter_pkg::RST_BLOCK;
        else if (wr_beg_cfg)
            beg_block_q <= wr_beg_block;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read back
    logic [ter_pkg::DATA_W-1:0] rd_trig_word;
    logic [ter_pkg::DATA_W-1:0] rd_evnt_word;
    logic [ter_pkg::DATA_W-1:0] rd_enab_word;
    logic [ter_pkg::DATA_W-1:0] rd_beg_word;
    logic [ter_pkg::DATA_W-1:0] rdata_d;

    assign rd_trig_word = {30'h0, trig_slope_q};
    assign rd_evnt_word = {30'h0, evnt_slope_q};
    assign rd_enab_word = {30'h0, enab_block_q, enab_src_q};
    assign rd_beg_word  = {31'h0, beg_block_q};

    always_comb
    begin
        rdata_d = '0;
        if (i_rd)
        begin
            unique case (i_addr)
                ter_pkg::REG_TRIG_SLOPE: rdata_d = rd_trig_word;
                ter_pkg::REG_EVNT_SLOPE: rdata_d = rd_evnt_word;
                ter_pkg::REG_ENAB_CFG:   rdata_d = rd_enab_word;
                ter_pkg::REG_BEG_CFG:    rdata_d = rd_beg_word;
                default:                 rdata_d = '0;
            endcase
        end
    end

    // Data stand one cycle, then zero
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_rdata <= '0;
        else
            o_rdata <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection
    ter_edge_if trig_e ();
    ter_edge_if evnt_e ();
    ter_edge_if igen_e ();

    assign trig_e.level = pin_sync[0];
    assign trig_e.slope = trig_slope_q;
    assign evnt_e.level = pin_sync[1];
    assign evnt_e.slope = evnt_slope_q;
    assign igen_e.level = pin_sync[2];
    assign igen_e.slope = ter_pkg::TER_EDGE_RISING;

    ter_edge_det u_trig
    (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .e      (trig_e)
    );

    ter_edge_det u_evnt
    (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .e      (evnt_e)
    );

    ter_edge_det u_igen
    (
        .i_mclk (i_mclk),
        .i_srst (i_srst),
        .e      (igen_e)
    );

    ////////////////////////////////////////////////////////////////////////
    // Detected edges
    logic trig_hit;
    logic evnt_hit;
    logic igen_hit;

    assign trig_hit = trig_e.hit;
    assign evnt_hit = evnt_e.hit;
    assign igen_hit = igen_e.hit;

    ////////////////////////////////////////////////////////////////////////
    // Software commands
    logic sw_enab;
    logic sw_beg;

    always_comb
    begin
        // Command pulses pass straight through
        sw_enab = i_cmd[ter_pkg::CMD_ENAB_BIT];
        sw_beg  = i_cmd[ter_pkg::CMD_BEG_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware event selection and gating
    logic hw_enab;
    logic hw_beg;
    logic hw_enab_open;
    logic hw_beg_open;

    always_comb
    begin
        hw_enab = (enab_src_q == ter_pkg::TER_SRC_EVNT) ? evnt_hit : trig_hit;
        hw_beg  = trig_hit | igen_hit;
    end

    always_comb
    begin
        hw_enab_open = hw_enab & ~enab_block_q;
        hw_beg_open  = hw_beg & ~beg_block_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event outputs
    logic enable_evt_d;
    logic begin_evt_d;

    always_comb
    begin
        enable_evt_d = sw_enab | hw_enab_open;
        begin_evt_d  = sw_beg | hw_beg_open;
    end

    // Registered enable event
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_enable_evt <= 1'h0;
        else
            o_enable_evt <= enable_evt_d;
    end

    // Registered begin event
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_begin_evt <= 1'h0;
        else
            o_begin_evt <= begin_evt_d;
    end

    // Command address port has no use here
    logic unused_ok;
    assign unused_ok = ^i_cmd_addr;

endmodule

/* File: test/ter_pin_src.sv */
// Far-side source of trigger, event and generator pin levels.
// Assumes the bench requests levels; pins change just after an edge.
module ter_pin_src
(
    input  wire logic       i_mclk,
    input  wire logic [2:0] i_lvl,
    output logic      [2:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_mclk)
    begin
        o_pins <= i_lvl;
    end
endmodule

/* File: test/ter_route_properties.sv */
// Port-level checks of the routing block.
// Assumes one clock and a synchronous active-high reset.
module ter_route_properties
(
    input wire logic        i_mclk,
    input wire logic        i_srst,
    input wire logic        i_trig_pin,
    input wire logic        i_evnt_pin,
    input wire logic        i_intgen_pin,
    input wire logic [3:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [3:0]  i_cmd_addr,
    input wire logic [1:0]  i_cmd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_enable_evt,
    input wire logic        o_begin_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  ts_q, es_q;
    logic        src_q, eb_q, bb_q, th, eh;
    logic [2:0]  p_q;
    logic [31:0] exp_rd;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    function automatic logic hit(logic [1:0] s, logic r, logic f);
        return (s == 2'h0 && r) || (s == 2'h1 && f) || (s == 2'h2 && (r || f));
    endfunction
    assign th = hit(ts_q, i_trig_pin & ~p_q[0], ~i_trig_pin & p_q[0]);
    assign eh = hit(es_q, i_evnt_pin & ~p_q[1], ~i_evnt_pin & p_q[1]);
    assign exp_rd = i_addr == 4'h0 ? {30'h0, ts_q} : i_addr == 4'h4 ? {30'h0, es_q} :
                    i_addr == 4'h8 ? {30'h0, eb_q, src_q} : i_addr == 4'hc ? {31'h0, bb_q} : 32'h0;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk)
    begin
        p_q <= {i_intgen_pin, i_evnt_pin, i_trig_pin};
        if (i_srst)
        begin
            ts_q <= 2'h0;
            es_q <= 2'h0;
            {eb_q, src_q, bb_q} <= 3'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == 4'h0 && i_wdata[1:0] != 2'h3) ts_q <= i_wdata[1:0];
            if (i_addr == 4'h4 && i_wdata[1:0] != 2'h3) es_q <= i_wdata[1:0];
            if (i_addr == 4'h8) {eb_q, src_q} <= i_wdata[1:0];
            if (i_addr == 4'hc) bb_q <= i_wdata[0];
        end
    end
    sequence pipe_en; ##3 o_enable_evt; endsequence
    sequence pipe_beg; ##3 o_begin_evt; endsequence
    ////////////////////////////////////////////////////////////////
    cmd_enab_a: assert property (i_cmd[0] |=> o_enable_evt) else $error("enable command lost");
    cmd_beg_a: assert property (i_cmd[1] |=> o_begin_evt) else $error("begin command lost");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
    rd_back_a: assert property (i_rd |=> o_rdata == $past(exp_rd)) else $error("read back wrong");
    en_block_a: assert property (eb_q && $past(eb_q, 4) && !$past(i_cmd[0]) |-> !o_enable_evt)
        else $error("blocked enable leaked");
    beg_block_a: assert property (bb_q && $past(bb_q, 4) && !$past(i_cmd[1]) |-> !o_begin_evt)
        else $error("blocked begin leaked");
    trig_beg_a: assert property (!bb_q && th |-> pipe_beg) else $error("trigger begin missed");
    gen_beg_a: assert property (!bb_q && i_intgen_pin && !p_q[2] |-> pipe_beg) else $error("gen begin missed");
    evt_en_a: assert property (!eb_q && src_q && eh |-> pipe_en) else $error("event enable missed");
    trig_en_a: assert property (!eb_q && !src_q && th |-> pipe_en) else $error("trigger enable missed");
endmodule
bind ter_route ter_route_properties chk (.*);

/* File: test/trigger_event_routing_tb.sv */
// Testbench for the routing block: register access, commands, pin edges.
// Assumes the pin source model drives the three input pins.
module trigger_event_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, en, bg;
    logic [3:0]  a = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0]  cmd = 2'h0;
    logic [2:0]  lvl = 3'h0, pins;
    int          num_errors = 0, n_tests = 0, cyc = 0, ne = 0, nb = 0;
    ter_pin_src src (.i_mclk(clk), .i_lvl(lvl), .o_pins(pins));
    ter_route dut (.i_mclk(clk), .i_srst(rst), .i_trig_pin(pins[0]), .i_evnt_pin(pins[1]),
        .i_intgen_pin(pins[2]), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_cmd_addr(4'h0),
        .i_cmd(cmd), .o_rdata(rdat), .o_enable_evt(en), .o_begin_evt(bg));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (en === 1'b1) ne++;
        if (bg === 1'b1) nb++;
        if (cyc > 3000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_t(logic [3:0] ad, logic [31:0] d);
        @(posedge clk) a <= ad; wd <= d; wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_t(logic [3:0] ad, logic [31:0] e);
        @(posedge clk) a <= ad; rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", rdat, e);
    endtask
    task automatic go(logic [2:0] l, logic [1:0] c, int e, int b);
        int e0, b0;
        e0 = ne;
        b0 = nb;
        @(posedge clk) lvl <= l; cmd <= c;
        @(posedge clk) cmd <= 2'h0;
        repeat (6) @(posedge clk);
        #1 chk("enable", ne - e0, e);
        chk("begin", nb - b0, b);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_t(ter_pkg::REG_TRIG_SLOPE, 32'h0);
        rd_t(ter_pkg::REG_EVNT_SLOPE, 32'h0);
        rd_t(ter_pkg::REG_ENAB_CFG, 32'h0);
        rd_t(ter_pkg::REG_BEG_CFG, 32'h0);
        rd_t(4'h2, 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            wr_t(4'h0, s);
            wr_t(4'h4, 2 - s);
            rd_t(4'h0, s);
            rd_t(4'h4, 2 - s);
        end
        wr_t(4'h0, 32'h3);
        rd_t(4'h0, 32'h2);
        wr_t(4'h0, 32'h0);
        wr_t(4'h4, 32'h0);
        wr_t(4'h8, 32'h2);
        wr_t(4'hc, 32'h1);
        rd_t(4'h8, 32'h2);
        rd_t(4'hc, 32'h1);
        go(3'h0, 2'h3, 1, 1);
        go(3'h7, 2'h0, 0, 0);
        go(3'h0, 2'h0, 0, 0);
        wr_t(4'h8, 32'h0);
        wr_t(4'hc, 32'h0);
        go(3'h1, 2'h0, 1, 1);
        go(3'h2, 2'h0, 0, 0);
        go(3'h6, 2'h0, 0, 1);
        go(3'h0, 2'h0, 0, 0);
        for (int s = 0; s < 3; s++)
        begin
            wr_t(4'h0, s);
            wr_t(4'h4, s);
            wr_t(4'h8, 32'h1);
            go(3'h3, 2'h0, s != 1, s != 1);
            go(3'h0, 2'h0, s != 0, s != 0);
        end
        wr_t(4'h8, 32'h3);
        go(3'h3, 2'h0, 0, 1);
        wrap_up();
    end
endmodule
